// File: verilog/fuse_prog_port.v
/*
 * parallel programming command layer with configuration fuses,
 * identification bytes, lock bits and paged flash and eeprom arrays.
 * assumes every programmer pin is asynchronous to clk and that each
 * programmer pulse lasts several clk periods; srst stands for power-up.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fuse_prog_regs.vh"

module fuse_prog_port #(
    parameter [16:0] prog_cycles = `PROG_CYCLES,
    parameter [7:0] ident_maker = 8'h5A, // arbitrary value
    parameter [7:0] ident_size = 8'h3C, // arbitrary value
    parameter [7:0] ident_part = 8'hA5, // arbitrary value
    parameter [7:0] trim_value = 8'h80
) (
    // clock and reset
    input wire clk,
    input wire srst,
    // mode pins
    input wire prog_enter,
    input wire serial_mode,
    // programmer strobes and selects
    input wire programming_strobe_clock,
    input wire action_select_lo,
    input wire action_select_hi,
    input wire byte_select_one,
    input wire write_n,
    input wire output_enable_n,
    // data pins
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe_n,
    output reg ready_not_busy,
    // configuration towards the core, latched except the keep flag
    output reg [7:0] low_config_active,
    output reg [7:0] high_config_active,
    output reg [7:0] extended_config_active,
    output reg data_memory_keep,
    output reg clock_to_pin_en,
    output reg [7:0] oscillator_trim_reg,
    output reg prog_mode_active
);

    localparam [2:0] st_normal = 3'b001;
    localparam [2:0] st_ready = 3'b010;
    localparam [2:0] st_busy = 3'b100;
    localparam [9:0] pin_idle = 10'h0C0;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // bit order: strobe, xa1, xa0, bs1, wr_n, oe_n, enter, serial ...
    reg [9:0] pin_s1;
    reg [9:0] pin_s2;
    reg [9:0] pin_d;
    reg [7:0] data_s1;
    reg [7:0] data_s2;
    wire [9:0] pins_raw = {2'h0, programming_strobe_clock,
        action_select_hi, action_select_lo, byte_select_one,
        write_n, output_enable_n, prog_enter, serial_mode};

    always @(posedge clk) begin
        if (srst) begin
            pin_s1 <= pin_idle;
            pin_s2 <= pin_idle;
            pin_d <= pin_idle;
            data_s1 <= 8'h00;
            data_s2 <= 8'h00;
        end else begin
            pin_s1 <= pins_raw;
            pin_s2 <= pin_s1;
            pin_d <= pin_s2;
            data_s1 <= data_in;
            data_s2 <= data_s1;
        end
    end

    wire strobe_rise = pin_s2[7] & ~pin_d[7];
    wire [1:0] action = pin_s2[6:5];
    wire byte_select_two = pin_s2[6];
    wire page_load_rise = pin_s2[4] & ~pin_d[4];
    wire byte_sel_one = pin_s2[4];
    wire write_fall = ~pin_s2[3] & pin_d[3];
    wire oe_low = ~pin_s2[2];
    wire enter_rise = pin_s2[1] & ~pin_d[1];
    wire enter_fall = ~pin_s2[1] & pin_d[1];
    wire serial_on = pin_s2[0];

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    reg [15:0] flash_mem [0:`FLASH_WORDS-1];
    reg [7:0] eeprom_mem [0:`EEPROM_BYTES-1];
    reg [15:0] flash_buf [0:`FLASH_PAGE_WORDS-1];
    reg [63:0] flash_buf_full;
    reg [7:0] eeprom_buf [0:`EEPROM_PAGE_BYTES-1];
    reg [3:0] eeprom_buf_full;
    // nonvolatile: factory values at start, kept through srst
    reg [7:0] low_config_byte = `LOW_CONFIG_RESET;
    reg [7:0] high_config_byte = `HIGH_CONFIG_RESET;
    reg [7:0] extended_config_byte = `EXT_CONFIG_RESET;
    reg [1:0] lock_bits = `LOCK_RESET;
    reg [7:0] command;
    reg [7:0] addr_low;
    reg [7:0] addr_high;
    reg [7:0] data_low;
    reg [7:0] data_high;
    reg [2:0] state;
    reg [7:0] op_cmd;
    reg [1:0] op_sel;
    reg [7:0] op_data;
    reg [16:0] busy_count;
    integer i;

    // flash word address: word in page 5:0, page 12:6
    wire [12:0] flash_addr = {addr_high[4:0], addr_low};
    wire [5:0] word_in_page_field = flash_addr[5:0];
    wire [6:0] page_select_field = flash_addr[12:6];
    // eeprom byte in page 1:0, page 8:2
    wire [8:0] eeprom_address_bits = {addr_high[0], addr_low};

    // byte selects: 0 low, 1 high, 2 extended, 3 lock
    function [1:0] fuse_sel;
        input bs1;
        input bs2;
        begin
            fuse_sel = {bs2, bs1 ^ bs2};
        end
    endfunction

    // extended byte keeps unused bits at one
    function [7:0] ext_clean;
        input [7:0] v;
        begin
            ext_clean = v | ~`EXT_USED_MASK;
        end
    endfunction

    wire locked_write = ~lock_bits[`BIT_LOCK_WRITE];
    wire locked_verify = locked_write & ~lock_bits[`BIT_LOCK_VERIFY];
    wire is_write_cmd = (command == `CMD_CHIP_ERASE) |
        (command == `CMD_WRITE_FUSE) | (command == `CMD_WRITE_LOCK) |
        (command == `CMD_WRITE_FLASH) | (command == `CMD_WRITE_EEPROM);

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    reg [7:0] next_read;
    always @* begin
        next_read = 8'hFF;
        case (command)
            `CMD_READ_IDENT: begin
                if (byte_sel_one) begin
                    next_read = (addr_low == `IDENT_ADDR_MAKER) ?
                        trim_value : 8'hFF;
                end else if (addr_low == `IDENT_ADDR_MAKER) begin
                    next_read = ident_maker;
                end else if (addr_low == `IDENT_ADDR_SIZE) begin
                    next_read = ident_size;
                end else if (addr_low == `IDENT_ADDR_PART) begin
                    next_read = ident_part;
                end
            end
            `CMD_READ_FUSE_LOCK: begin
                case (fuse_sel(byte_sel_one, byte_select_two))
                    2'h0: next_read = low_config_byte;
                    2'h1: next_read = high_config_byte |
                        {2'h0, serial_on, 5'h00}; // hidden
                    2'h2: next_read = ext_clean(extended_config_byte);
                    default: next_read = {6'h3F, lock_bits};
                endcase
            end
            `CMD_READ_FLASH: begin
                if (!locked_verify) begin
                    next_read = byte_sel_one ?
                        flash_mem[flash_addr][15:8] :
                        flash_mem[flash_addr][7:0];
                end
            end
            `CMD_READ_EEPROM: begin
                if (!locked_verify) begin
                    next_read = eeprom_mem[eeprom_address_bits];
                end
            end
            default: next_read = 8'hFF;
        endcase
    end

    // ------------------------------------------------------------
    // command layer
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            state <= st_normal;
            command <= `CMD_NOP;
            addr_low <= 8'h00;
            addr_high <= 8'h00;
            data_low <= 8'hFF;
            data_high <= 8'hFF;
            op_cmd <= `CMD_NOP;
            op_sel <= 2'h0;
            op_data <= 8'hFF;
            busy_count <= 17'h00000;
            flash_buf_full <= 64'h0;
            eeprom_buf_full <= 4'h0;
        end else begin
            case (state)
                st_normal: begin
                    // entry only with all four enable pins low
                    if (enter_rise && pin_s2[6:3] == 4'h0) begin
                        state <= st_ready;
                    end
                end
                st_ready: begin
                    if (enter_fall) begin
                        state <= st_normal;
                    end else if (strobe_rise) begin
                        case (action)
                            `ACT_LOAD_ADDR: begin
                                if (byte_sel_one) begin
                                    addr_high <= data_s2;
                                end else begin
                                    addr_low <= data_s2;
                                end
                            end
                            `ACT_LOAD_DATA: begin
                                if (byte_sel_one) begin
                                    data_high <= data_s2;
                                end else begin
                                    data_low <= data_s2;
                                end
                            end
                            `ACT_LOAD_CMD: begin
                                command <= data_s2;
                                if (data_s2 == `CMD_NOP) begin
                                    flash_buf_full <= 64'h0;
                                    eeprom_buf_full <= 4'h0;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end else if (page_load_rise) begin
                        if (command == `CMD_WRITE_FLASH) begin
                            flash_buf[word_in_page_field] <=
                                {data_high, data_low};
                            flash_buf_full[word_in_page_field] <= 1'b1;
                        end else if (command == `CMD_WRITE_EEPROM) begin
                            eeprom_buf[eeprom_address_bits[1:0]] <=
                                data_low;
                            eeprom_buf_full[eeprom_address_bits[1:0]]
                                <= 1'b1;
                        end
                    end else if (write_fall && is_write_cmd) begin
                        op_cmd <= command;
                        op_sel <= fuse_sel(byte_sel_one, byte_select_two);
                        op_data <= data_low;
                        busy_count <= prog_cycles;
                        state <= st_busy;
                    end
                end
                st_busy: begin
                    // pins are not looked at until done
                    if (busy_count > 17'h00001) begin
                        busy_count <= busy_count - 17'h00001;
                    end else begin
                        state <= st_ready;
                        case (op_cmd)
                            `CMD_CHIP_ERASE: begin
                                for (i = 0; i < `FLASH_WORDS; i = i + 1) begin
                                    flash_mem[i] <= 16'hFFFF;
                                end
                                if (high_config_byte[`BIT_DATA_MEMORY_KEEP])
                                begin
                                    for (i = 0; i < `EEPROM_BYTES;
                                        i = i + 1) begin
                                        eeprom_mem[i] <= 8'hFF;
                                    end
                                end
                                lock_bits <= `LOCK_RESET;
                            end
                            `CMD_WRITE_FUSE: begin
                                if (!locked_write) begin
                                    case (op_sel)
                                        2'h0: low_config_byte <= op_data;
                                        2'h1: high_config_byte <= serial_on ?
                                            {op_data[7:6],
                                            high_config_byte[5],
                                            op_data[4:0]} :
                                            op_data;
                                        default: extended_config_byte <=
                                            ext_clean(op_data);
                                    endcase
                                end
                            end
                            `CMD_WRITE_LOCK: begin
                                lock_bits <= lock_bits & op_data[1:0];
                            end
                            `CMD_WRITE_FLASH: begin
                                for (i = 0; i < `FLASH_PAGE_WORDS;
                                    i = i + 1) begin
                                    if (flash_buf_full[i] && !locked_write)
                                    begin
                                        flash_mem[{page_select_field,
                                            i[5:0]}] <= flash_buf[i];
                                    end
                                end
                            end
                            default: begin
                                for (i = 0; i < `EEPROM_PAGE_BYTES;
                                    i = i + 1) begin
                                    if (eeprom_buf_full[i] && !locked_write)
                                    begin
                                        eeprom_mem[{eeprom_address_bits[8:2],
                                            i[1:0]}] <= eeprom_buf[i];
                                    end
                                end
                            end
                        endcase
                    end
                end
                default: state <= st_normal;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs and fuse latching
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            data_out <= 8'hFF;
            data_oe_n <= 1'b1;
            ready_not_busy <= 1'b1;
            low_config_active <= `LOW_CONFIG_RESET;
            high_config_active <= `HIGH_CONFIG_RESET;
            extended_config_active <= `EXT_CONFIG_RESET;
            data_memory_keep <= 1'b0;
            clock_to_pin_en <= 1'b0;
            oscillator_trim_reg <= trim_value;
            prog_mode_active <= 1'b0;
        end else begin
            // drive data only while output enable is low
            data_oe_n <= ~(oe_low && state == st_ready);
            data_out <= next_read;
            ready_not_busy <= (state != st_busy);
            prog_mode_active <= (state != st_normal);
            // latched copies change only outside programming
            if (state == st_normal) begin
                low_config_active <= low_config_byte;
                high_config_active <= high_config_byte;
                extended_config_active <= ext_clean(extended_config_byte);
            end
            // keep fuse bypasses the latch
            data_memory_keep <= ~high_config_byte[`BIT_DATA_MEMORY_KEEP];
            // programmed (zero) clock output fuse enables the pin
            clock_to_pin_en <= ~low_config_active[`BIT_CLOCK_TO_PIN];
        end
    end

endmodule
`default_nettype wire

// File: pkg/fuse_prog_regs.vh
/*
 * constants of the parallel programming port: commands, fuse layout,
 * fuse and lock defaults, identification addresses and timing.
 * assumes it is included once per compilation unit by its bare name.
 */
`ifndef FUSE_PROG_REGS_VH
`define FUSE_PROG_REGS_VH

// ----------------------------------------------------------------
// command bytes
// ----------------------------------------------------------------
`define CMD_NOP 8'h00
`define CMD_CHIP_ERASE 8'h80
`define CMD_WRITE_FUSE 8'h40
`define CMD_WRITE_LOCK 8'h20
`define CMD_WRITE_FLASH 8'h10
`define CMD_WRITE_EEPROM 8'h11
`define CMD_READ_IDENT 8'h08
`define CMD_READ_FUSE_LOCK 8'h04
`define CMD_READ_FLASH 8'h02
`define CMD_READ_EEPROM 8'h03

// ----------------------------------------------------------------
// action select codes {hi, lo}
// ----------------------------------------------------------------
`define ACT_LOAD_ADDR 2'h0
`define ACT_LOAD_DATA 2'h1
`define ACT_LOAD_CMD 2'h2
`define ACT_IDLE 2'h3

// ----------------------------------------------------------------
// fuse bytes, reset values and field positions
// ----------------------------------------------------------------
`define LOW_CONFIG_RESET 8'h62
`define HIGH_CONFIG_RESET 8'hDF
`define EXT_CONFIG_RESET 8'hFF
`define LOCK_RESET 2'h3
`define EXT_USED_MASK 8'h01
`define BIT_SELF_WRITE_ENABLE 0
`define BIT_EXTERNAL_RESET_OFF 7
`define BIT_ONE_WIRE_DEBUG_ON 6
`define BIT_SERIAL_DOWNLOAD_ON 5
`define BIT_WATCHDOG_FORCED 4
`define BIT_DATA_MEMORY_KEEP 3
`define BIT_CLOCK_DIVIDE_EIGHT 7
`define BIT_CLOCK_TO_PIN 6
`define BIT_LOCK_WRITE 0
`define BIT_LOCK_VERIFY 1

// ----------------------------------------------------------------
// identification space and memory organisation
// ----------------------------------------------------------------
`define IDENT_ADDR_MAKER 8'h00
`define IDENT_ADDR_SIZE 8'h01
`define IDENT_ADDR_PART 8'h02
`define FLASH_WORDS 8192
`define FLASH_PAGE_WORDS 64
`define EEPROM_BYTES 512
`define EEPROM_PAGE_BYTES 4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define PROG_TIME_NS 4500000
// PROG_TIME_NS over CLK_PERIOD_NS, sized for the 17-bit busy counter
`define PROG_CYCLES 17'h0AFC8

`endif

// File: bench/fuse_prog_assertions.sv
/* checker on the ports of fuse_prog_port.
   assumes one clock clk and a synchronous active-high srst. */
`timescale 1ns/1ns
`default_nettype none
module fuse_prog_assertions #(
    parameter [16:0] prog_cycles = 17'h00005,
    parameter [7:0] trim_value = 8'h80
) (
    // clock, reset and pin seen
    input wire clk,
    input wire srst,
    input wire output_enable_n,
    // device outputs
    input wire data_oe_n,
    input wire ready_not_busy,
    input wire [7:0] low_config_active,
    input wire [7:0] high_config_active,
    input wire [7:0] extended_config_active,
    input wire clock_to_pin_en,
    input wire [7:0] oscillator_trim_reg,
    input wire prog_mode_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic [16:0] busy_cnt;
    // counts low samples of ready; a counter avoids a long repetition
    always @(posedge clk) begin
        if (srst || ready_not_busy)
            busy_cnt <= 17'h0;
        else
            busy_cnt <= busy_cnt + 17'h1;
    end
    a_busy_length: assert property (
        $rose(ready_not_busy) |-> busy_cnt >= prog_cycles &&
        busy_cnt <= prog_cycles + 17'h2) else $error("busy length wrong");
    a_busy_in_prog: assert property (
        !ready_not_busy |-> prog_mode_active) else $error("busy outside");
    a_oe_needs_prog: assert property (
        !data_oe_n |-> prog_mode_active) else $error("drive outside");
    a_oe_release: assert property (
        $rose(output_enable_n) |-> ##[1:8] data_oe_n)
        else $error("bus not released");
    a_oe_answer: assert property (
        $fell(output_enable_n) && prog_mode_active && ready_not_busy
        |-> ##[2:8] !data_oe_n) else $error("bus not driven");
    a_fuse_frozen: assert property (
        prog_mode_active && $past(prog_mode_active) |->
        $stable(low_config_active) && $stable(high_config_active) &&
        $stable(extended_config_active)) else $error("fuse moved");
    a_clock_pin: assert property (
        clock_to_pin_en == !low_config_active[6] ||
        clock_to_pin_en == !$past(low_config_active[6]))
        else $error("clock pin wrong");
    a_ext_ones: assert property (
        extended_config_active[7:1] == 7'h7F) else $error("ext bits");
    a_trim_reset: assert property (
        $fell(srst) |-> oscillator_trim_reg == trim_value)
        else $error("trim not loaded");
endmodule
bind fuse_prog_port fuse_prog_assertions #(.prog_cycles(prog_cycles),
    .trim_value(trim_value)) chk_i (.clk(clk), .srst(srst),
    .output_enable_n(output_enable_n), .data_oe_n(data_oe_n),
    .ready_not_busy(ready_not_busy), .low_config_active(low_config_active),
    .high_config_active(high_config_active),
    .extended_config_active(extended_config_active),
    .clock_to_pin_en(clock_to_pin_en), .prog_mode_active(prog_mode_active),
    .oscillator_trim_reg(oscillator_trim_reg));
`default_nettype wire

// File: bench/prog_host.sv
/* parallel programmer model with tasks for loads, writes and reads.
   assumes tasks are called at a falling edge of clk. */
`timescale 1ns/1ns
`default_nettype none
module prog_host (
    // clock and device answers
    input wire clk,
    input wire [7:0] data_out,
    input wire data_oe_n,
    input wire ready_not_busy,
    // programmer pins
    output logic prog_enter,
    output logic programming_strobe_clock,
    output logic action_select_lo,
    output logic action_select_hi,
    output logic byte_select_one,
    output logic write_n,
    output logic output_enable_n,
    output logic [7:0] data_in,
    output logic busy_seen
);
    logic [7:0] drv;
    logic drv_en;
    // a released bus shows the inverse, never a stale copy
    assign data_in = !data_oe_n ? data_out : drv_en ? drv : ~drv;
    initial begin
        {prog_enter, programming_strobe_clock, write_n} = 3'h0;
        {action_select_hi, action_select_lo, byte_select_one} = 3'h0;
        {output_enable_n, drv_en, busy_seen, drv} = 11'h600;
    end
    task automatic hold; // 400 ns per phase
        repeat (4) @(negedge clk);
    endtask
    task automatic ld(input [1:0] act, input b1, input [7:0] d);
        {action_select_hi, action_select_lo} = act;
        byte_select_one = b1;
        drv = d;
        hold();
        programming_strobe_clock = 1'b1;
        hold();
        programming_strobe_clock = 1'b0;
        hold();
    endtask
    task automatic wr_go(input b2, input b1);
        busy_seen = 1'b0;
        {action_select_hi, action_select_lo} = {b2, 1'b1};
        byte_select_one = b1;
        hold(); // selects settle before the write edge
        write_n = 1'b0;
        hold();
        write_n = 1'b1;
    endtask
    task automatic wr_wait; // no new command until ready
        int i;
        for (i = 0; i < 300 && !(busy_seen && ready_not_busy); i++) begin
            @(negedge clk);
            if (!ready_not_busy)
                busy_seen = 1'b1;
        end
        hold();
    endtask
    task automatic rd(input b2, input b1, output [7:0] q, output o);
        action_select_hi = b2;
        byte_select_one = b1;
        drv_en = 1'b0;
        output_enable_n = 1'b0;
        repeat (8) @(negedge clk);
        q = data_in;
        o = data_oe_n;
        output_enable_n = 1'b1;
        repeat (8) @(negedge clk);
        drv_en = 1'b1;
    endtask
    task automatic enter;
        prog_enter = 1'b1;
        hold();
        write_n = 1'b1;
        {action_select_hi, action_select_lo} = 2'h3;
        hold();
    endtask
    task automatic leave;
        prog_enter = 1'b0;
        repeat (8) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
/* self-checking bench for fuse_prog_port.
   assumes prog_host drives the pins and the checker is bound. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk, srst, serial_mode, o;
    logic [7:0] q;
    int err_count, checked, i;
    wire pe, stb, alo, ahi, bs1, wn, oen, doe, rdy, keep, cpin, pm, seen;
    wire [7:0] din, dout, lo_c, hi_c, ex_c, trim;
    // cmd, addr, {bs2,bs1}, expected: ident, trim, fuses, lock
    logic [31:0] rows [8] = '{32'h0800005A, 32'h0801003C, 32'h080200A5,
        32'h08000180, 32'h04000062, 32'h040001DF, 32'h040003FF,
        32'h040002FF};
    fuse_prog_port #(.prog_cycles(17'h00028)) DUT (.clk(clk), .srst(srst),
        .prog_enter(pe), .serial_mode(serial_mode),
        .programming_strobe_clock(stb), .action_select_lo(alo),
        .action_select_hi(ahi), .byte_select_one(bs1), .write_n(wn),
        .output_enable_n(oen), .data_in(din), .data_out(dout),
        .data_oe_n(doe), .ready_not_busy(rdy), .low_config_active(lo_c),
        .high_config_active(hi_c), .extended_config_active(ex_c),
        .data_memory_keep(keep), .clock_to_pin_en(cpin),
        .oscillator_trim_reg(trim), .prog_mode_active(pm));
    prog_host host (.clk(clk), .data_out(dout), .data_oe_n(doe),
        .ready_not_busy(rdy), .prog_enter(pe), .programming_strobe_clock(stb),
        .action_select_lo(alo), .action_select_hi(ahi),
        .byte_select_one(bs1), .write_n(wn), .output_enable_n(oen),
        .data_in(din), .busy_seen(seen));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string n, input [7:0] e, input [7:0] g);
        checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard, over twenty times the expected run
    initial begin
        #2000000;
        err_count++;
        report_and_stop();
    end
    initial begin
        {srst, serial_mode} = 2'h2;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        chk("trim", 8'h80, trim);
        chk("low", 8'h62, lo_c);
        chk("high", 8'hDF, hi_c);
        chk("ext", 8'hFF, ex_c);
        chk("flags", 8'h03, {3'h0, keep, cpin, pm, doe, rdy});
        $display("reset test done");
        host.enter();
        chk("mode", 8'h01, {7'h0, pm});
        for (i = 0; i < 8; i++) begin
            host.ld(2'h2, 1'b0, rows[i][31:24]);
            host.ld(2'h0, 1'b0, rows[i][23:16]);
            host.rd(rows[i][9], rows[i][8], q, o);
            chk("read", rows[i][7:0], q);
            chk("drive", 8'h00, {7'h0, o});
        end
        $display("table test done");
        host.ld(2'h2, 1'b0, 8'h40);
        host.ld(2'h1, 1'b0, 8'h22);
        host.wr_go(1'b0, 1'b0);
        host.wr_wait();
        chk("busy", 8'h01, {7'h0, seen});
        host.ld(2'h1, 1'b0, 8'hD7);
        host.wr_go(1'b0, 1'b1);
        host.wr_wait();
        chk("keep", 8'h01, {7'h0, keep});
        chk("held low", 8'h62, lo_c);
        host.ld(2'h1, 1'b0, 8'hFE);
        host.wr_go(1'b1, 1'b0);
        host.ld(2'h1, 1'b0, 8'hFF); // lands while busy, must be dropped
        host.wr_wait();
        host.wr_go(1'b1, 1'b0);
        host.wr_wait();
        host.ld(2'h2, 1'b0, 8'h04);
        host.rd(1'b0, 1'b0, q, o);
        chk("stored low", 8'h22, q);
        host.rd(1'b1, 1'b1, q, o);
        chk("stored ext", 8'hFE, q);
        serial_mode = 1'b1;
        host.rd(1'b0, 1'b1, q, o);
        chk("hidden", 8'hF7, q);
        serial_mode = 1'b0;
        host.ld(2'h2, 1'b0, 8'h80);
        host.wr_go(1'b0, 1'b0);
        host.wr_wait();
        host.ld(2'h2, 1'b0, 8'h10);
        host.ld(2'h0, 1'b0, 8'h05);
        host.ld(2'h1, 1'b1, 8'h12);
        host.ld(2'h1, 1'b0, 8'h34);
        host.ld(2'h0, 1'b1, 8'h00); // rising select latches word 5
        host.wr_go(1'b0, 1'b0);
        host.wr_wait();
        host.ld(2'h2, 1'b0, 8'h00);
        host.ld(2'h2, 1'b0, 8'h02);
        host.rd(1'b0, 1'b0, q, o);
        chk("flash low", 8'h34, q);
        host.rd(1'b0, 1'b1, q, o);
        chk("flash high", 8'h12, q);
        host.ld(2'h0, 1'b0, 8'h06);
        host.rd(1'b0, 1'b0, q, o);
        chk("erased", 8'hFF, q);
        host.leave();
        chk("low", 8'h22, lo_c);
        chk("clock pin", 8'h01, {7'h0, cpin});
        chk("ext", 8'hFE, ex_c);
        $display("write test done");
        srst = 1'b1;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        repeat (8) @(negedge clk);
        chk("low kept", 8'h22, lo_c);
        chk("trim", 8'h80, trim);
        $display("second reset test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
